// ---- design/ssc_pkg.sv ----
package ssc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CLK  = 8'h00;
   localparam logic [7:0] OFS_MOD  = 8'h04;
   localparam logic [7:0] OFS_BR   = 8'h08;
   localparam logic [7:0] OFS_CTL  = 8'h0C;
   localparam logic [7:0] OFS_TXD  = 8'h10;
   localparam logic [7:0] OFS_RXD  = 8'h14;
   localparam logic [7:0] OFS_WTC0 = 8'h18;
   localparam logic [7:0] OFS_WTC1 = 8'h1C;
   localparam logic [7:0] OFS_GTC  = 8'h20;
   localparam logic [7:0] OFS_INTF = 8'h24;
   localparam logic [7:0] OFS_INTE = 8'h28;
   // field positions
   localparam int CLK_DEBUG_CLOCK_KEEP = 8;
   localparam int CLK_DIV   = 4;
   localparam int MOD_PRT   = 7;
   localparam int MOD_PRY   = 6;
   localparam int MOD_INV   = 5;
   localparam int MOD_DIR   = 4;
   localparam int MOD_OD    = 2;
   localparam int MOD_CPOL  = 1;
   localparam int MOD_MST   = 0;
   localparam int CTL_COLD  = 11;
   localparam int CTL_CKO   = 10;
   localparam int CTL_RECEIVE_ENABLE  = 9;
   localparam int CTL_TRANSMIT_ENABLE  = 8;
   localparam int CTL_CRP   = 4;
   localparam int CTL_SRST  = 1;
   localparam int CTL_ON    = 0;
   // event flag positions
   localparam int F_WTE = 7;
   localparam int F_TEND = 6;
   localparam int F_EDT = 5;
   localparam int F_PE  = 4;
   localparam int F_OE  = 3;
   localparam int F_RB2 = 2;
   localparam int F_RB1 = 1;
   localparam int F_TBE = 0;
   // reset values and etu counts
   localparam logic [10:0] FDR_RST   = 11'h173;
   localparam logic [7:0]  FLAG_RST  = 8'h01;
   localparam logic [8:0]  GT_BASE   = 9'h00C;
   localparam logic [8:0]  GT_T1_MIN = 9'h00B;
   localparam logic [8:0]  RETX_GAP  = 9'h00D;
   localparam logic [8:0]  ERR_ETU   = 9'h00A;
   localparam logic [8:0]  PAR_ETU   = 9'h009;
   localparam logic [8:0]  ESIG_END  = 9'h00B;
   typedef enum {S_IDLE, S_CHAR} ssc_state_type;
endpackage

// ---- design/ssc_top.sv ----
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - debug halt stops the operating clock unless debug_clock_keep is set
// - source_select picks source; divider applies to sources 0 and 2 only
// - clock register writes take effect only while module_on is 0
// - protocol_select picks T=1 or T=0; parity_sense picks odd or even
// - level_flip inverts line both ways; bit_order picks msb or lsb first
// - pad_drive_type selects open drain (reset) or push-pull on card io
// - card clock driven only with card_clock_drive; idle level in master role
// - controller_role 1 is master (reset), 0 is slave
// - etu is rate_factor plus one card clocks, reset 0x173
// - cold_wait_count write 1 with receive off starts wait count; 0 stops
// - receive_enable starts start-bit detection; clearing it stops reception
// - with transmit_enable set a transmit buffer write starts a character
// - T=0 receive parity error with repeat_on_error sends error signal, clears bit
// - T=0 transmit error signal with repeat_on_error resends byte, clears bit
// - soft_reset_cmd resets tx/rx control and flags, reads 1, self clears
// - module_on enables and gates the operating clock
// - transmit buffer writes accepted only with module_on and transmit_enable
// - receive register returns oldest of two bytes plus parity fail bit
// - 24-bit wait limit compared unmodified with etu count
// - guard is guard_extra plus 12; 255 gives 12 in T=0, 11 in T=1
// - status shows activity bits; event flags 7 to 3 clear on writing 1
// - interrupt request only for a set flag whose enable bit is set
// - tx_empty_flag resets to 1, clears on tx write; rx full flags clear on read
module ssc_top (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // clock sources and debug
   input  wire logic [3:0]  source_tick,
   input  wire logic        debug_halt,
   // card io pin
   input  wire logic        card_io_in,
   output logic             card_io_out,
   output logic             card_io_oe,
   // card clock pin
   input  wire logic        card_clock_in,
   output logic             card_clock_out,
   output logic             card_clock_oe,
   // interrupt request
   output logic             irq
);
   import ssc_pkg::*;

   // bus decode
   wire wr_en = psel & penable & pwrite;
   wire rd_en = psel & penable & ~pwrite;
   wire setup = psel & ~penable;
   wire sel_clk  = paddr == OFS_CLK;
   wire sel_mod  = paddr == OFS_MOD;
   wire sel_br   = paddr == OFS_BR;
   wire sel_ctl  = paddr == OFS_CTL;
   wire sel_txd  = paddr == OFS_TXD;
   wire sel_rxd  = paddr == OFS_RXD;
   wire sel_wt0  = paddr == OFS_WTC0;
   wire sel_wt1  = paddr == OFS_WTC1;
   wire sel_gtc  = paddr == OFS_GTC;
   wire sel_intf = paddr == OFS_INTF;
   wire sel_inte = paddr == OFS_INTE;
   wire hit = sel_clk | sel_mod | sel_br | sel_ctl | sel_txd | sel_rxd
            | sel_wt0 | sel_wt1 | sel_gtc | sel_intf | sel_inte;

   // registers
   logic        debug_clock_keep_q, on_q, t1_q, odd_q, inv_q, msb_q, od_q, cpol_q, mst_q;
   logic [1:0]  div_q, src_q;
   logic [10:0] fdr_q;
   logic        cko_q, receive_enable_q, transmit_enable_q, crp_q, srst_q;
   logic [7:0]  txd_q, gtc_q, flg_q, inte_q;
   logic [23:0] wtc_q;
   logic [31:0] prdata_q;

   // engine state
   ssc_state_type st_q;
   logic        txdir_q, retx_q, pend_q, esig_q;
   logic [10:0] sub_q;
   logic [8:0]  bit_q;
   logic [7:0]  rsh_q;
   logic [2:0]  dc_q;
   logic        phase_q, wt_run_q, cold_q;
   logic [23:0] wt_q;
   logic        io1_q, io2_q, ck1_q, ck2_q, ck3_q;
   logic        drv_q, lvl_q;
   logic [8:0]  fifo_q [2];
   logic        rp_q;
   logic [1:0]  cnt_q;

   function automatic logic tx_level(input logic [8:0] b, input logic [7:0] d,
                                     input logic msb, input logic odd);
      logic [2:0] i;
      i = 3'h0;
      if (b == 9'h000) begin
         tx_level = 1'b0;
      end else if (b <= 9'h008) begin
         i = msb ? 3'(9'h008 - b) : 3'(b - 9'h001);
         tx_level = d[i];
      end else begin
         tx_level = ^d ^ odd;
      end
   endfunction

   // operating clock: source select, divide, gate
   wire run = on_q & (~debug_halt | debug_clock_keep_q);
   wire src_t = source_tick[src_q];
   wire divd = (src_q == 2'h0) | (src_q == 2'h2);
   wire [2:0] dmask = divd ? 3'((4'h1 << div_q) - 4'h1) : 3'h0;
   wire op_tick = run & src_t & (dc_q == dmask);

   // card clock and etu timing
   wire m_rise = op_tick & ~phase_q;
   wire s_rise = run & ck2_q & ~ck3_q;
   wire cc_rise = mst_q ? m_rise : s_rise;
   wire etu_tick = cc_rise & (sub_q == fdr_q);
   wire mid_tick = cc_rise & (sub_q == (fdr_q >> 1));
   wire rx_bit = io2_q ^ inv_q;

   // guard time
   wire [8:0] gt = (gtc_q == 8'hFF) ? (t1_q ? GT_T1_MIN : GT_BASE)
                                    : ({1'b0, gtc_q} + GT_BASE);
   wire [8:0] tgt = retx_q ? RETX_GAP : gt;
   wire char_end = (st_q == S_CHAR) & etu_tick & (bit_q == tgt - 9'h001);

   // start conditions
   wire start_tx = (st_q == S_IDLE) & pend_q & transmit_enable_q & on_q;
   wire start_rx = (st_q == S_IDLE) & ~start_tx & receive_enable_q & ~rx_bit
                 & ~pend_q & cc_rise;
   wire rx_par = (st_q == S_CHAR) & ~txdir_q & mid_tick & (bit_q == PAR_ETU);
   wire par_bad = rx_par & ((^rsh_q ^ odd_q) != rx_bit);
   wire err_chk = (st_q == S_CHAR) & txdir_q & ~t1_q & crp_q & etu_tick
                & (bit_q == ERR_ETU);
   wire err_hit = err_chk & ~rx_bit;
   wire ask_retx = par_bad & ~t1_q & crp_q;

   // register writes
   wire w_ctl  = wr_en & sel_ctl;
   wire w_txd  = wr_en & sel_txd & on_q & transmit_enable_q;
   wire w_clk  = wr_en & sel_clk & ~on_q;
   wire r_rxd  = rd_en & sel_rxd;
   wire cold_on  = w_ctl & pwdata[CTL_COLD] & ~pwdata[CTL_RECEIVE_ENABLE];
   wire cold_off = w_ctl & ~pwdata[CTL_COLD] & cold_q;
   wire receive_enable_up  = w_ctl & pwdata[CTL_RECEIVE_ENABLE] & ~receive_enable_q;
   wire wt_hit   = wt_run_q & etu_tick & (wt_q == wtc_q);

   // receive fifo
   wire pop  = r_rxd & (cnt_q != 2'h0);
   wire full = (cnt_q == 2'h2) & ~pop;
   wire push = rx_par & ~full;
   wire ovr  = rx_par & full;
   wire wp   = rp_q ^ cnt_q[0];

   // event flags, set wins over clear
   logic [7:0] fset, fclr;
   always_comb begin
      fset = 8'h00;
      fset[F_WTE]  = wt_hit;
      fset[F_EDT]  = err_hit;
      fset[F_PE]   = par_bad;
      fset[F_OE]   = ovr;
      fset[F_RB1]  = push & (cnt_q == 2'h0);
      fset[F_RB2]  = push & (cnt_q == 2'h1) & ~pop;
      fset[F_TBE]  = (start_tx & t1_q) | (char_end & txdir_q & ~t1_q & ~retx_q);
      fset[F_TEND] = char_end & txdir_q & ~retx_q & ~(t1_q & pend_q);
      fclr = 8'h00;
      if (wr_en & sel_intf) begin
         fclr[7:3] = pwdata[7:3];
      end
      fclr[F_RB1] = r_rxd;
      fclr[F_RB2] = r_rxd;
      fclr[F_TBE] = w_txd;
   end

   // line drive
   wire tx_drv = (st_q == S_CHAR) & txdir_q & (bit_q <= PAR_ETU);
   wire drv_d = tx_drv | esig_q;
   wire lvl_d = tx_drv ? (tx_level(bit_q, txd_q, msb_q, odd_q) ^ inv_q) : 1'b0;

   // read mux
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      if (sel_clk) rdata[8:0] = {debug_clock_keep_q, 2'h0, div_q, 2'h0, src_q};
      if (sel_mod) rdata[7:0] = {t1_q, odd_q, inv_q, msb_q, 1'b0, od_q, cpol_q, mst_q};
      if (sel_br) rdata[10:0] = fdr_q;
      if (sel_ctl) rdata[11:0] = {cold_q, cko_q, receive_enable_q, transmit_enable_q, 3'h0, crp_q,
                                  2'h0, srst_q, on_q};
      if (sel_txd) rdata[7:0] = txd_q;
      if (sel_rxd) rdata[8:0] = fifo_q[rp_q];
      if (sel_wt0) rdata[15:0] = wtc_q[15:0];
      if (sel_wt1) rdata[7:0] = wtc_q[23:16];
      if (sel_gtc) rdata[7:0] = gtc_q;
      if (sel_intf) rdata[11:0] = {wt_run_q, (st_q == S_CHAR) & (bit_q >= ERR_ETU),
                                   (st_q == S_CHAR) & ~txdir_q,
                                   (st_q == S_CHAR) & txdir_q, flg_q};
      if (sel_inte) rdata[7:0] = inte_q;
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign irq = |(flg_q & inte_q);
   assign card_io_out = od_q ? 1'b0 : lvl_q;
   assign card_io_oe  = od_q ? (drv_q & ~lvl_q) : drv_q;
   assign card_clock_oe  = mst_q;
   assign card_clock_out = mst_q & (cko_q ? phase_q : cpol_q);

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {debug_clock_keep_q, div_q, src_q} <= 5'h00;
         {t1_q, odd_q, inv_q, msb_q, cpol_q} <= 5'h00;
         od_q <= 1'b1;
         mst_q <= 1'b1;
         fdr_q <= FDR_RST;
         {cko_q, receive_enable_q, transmit_enable_q, on_q} <= 4'h0;
         txd_q <= 8'h00;
         wtc_q <= 24'h00_0000;
         gtc_q <= 8'h00;
         inte_q <= 8'h00;
         prdata_q <= 32'h0000_0000;
      end else begin
         if (setup) prdata_q <= rdata;
         if (w_clk) begin
            debug_clock_keep_q <= pwdata[CLK_DEBUG_CLOCK_KEEP];
            div_q <= pwdata[CLK_DIV+:2];
            src_q <= pwdata[1:0];
         end
         if (wr_en & sel_mod) begin
            t1_q <= pwdata[MOD_PRT];
            odd_q <= pwdata[MOD_PRY];
            inv_q <= pwdata[MOD_INV];
            msb_q <= pwdata[MOD_DIR];
            od_q <= pwdata[MOD_OD];
            cpol_q <= pwdata[MOD_CPOL];
            mst_q <= pwdata[MOD_MST];
         end
         if (wr_en & sel_br) fdr_q <= pwdata[10:0];
         if (w_ctl) begin
            cko_q <= pwdata[CTL_CKO];
            receive_enable_q <= pwdata[CTL_RECEIVE_ENABLE];
            transmit_enable_q <= pwdata[CTL_TRANSMIT_ENABLE];
            on_q <= pwdata[CTL_ON];
         end
         if (w_txd) txd_q <= pwdata[7:0];
         if (wr_en & sel_wt0) wtc_q[15:0] <= pwdata[15:0];
         if (wr_en & sel_wt1) wtc_q[23:16] <= pwdata[7:0];
         if (wr_en & sel_gtc) gtc_q <= pwdata[7:0];
         if (wr_en & sel_inte) inte_q <= pwdata[7:0];
      end
   end

   // synchronisers, divider and card clock phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {io1_q, io2_q} <= 2'h3;
         {ck1_q, ck2_q, ck3_q} <= 3'h0;
         dc_q <= 3'h0;
         phase_q <= 1'b0;
      end else begin
         io1_q <= card_io_in;
         io2_q <= io1_q;
         ck1_q <= card_clock_in;
         ck2_q <= ck1_q;
         ck3_q <= ck2_q;
         if (run & src_t) dc_q <= (dc_q == dmask) ? 3'h0 : dc_q + 3'h1;
         if (op_tick) phase_q <= ~phase_q;
      end
   end

   // flags, soft reset, repeat bit, fifo
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flg_q <= FLAG_RST;
         srst_q <= 1'b0;
         crp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
         fifo_q[0] <= 9'h000;
         fifo_q[1] <= 9'h000;
      end else begin
         // one busy cycle, then self clear; writes of 0 are ignored
         srst_q <= w_ctl & pwdata[CTL_SRST];
         if (srst_q) begin
            flg_q <= FLAG_RST;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
         end else begin
            flg_q <= (flg_q & ~fclr) | fset;
            if (push) fifo_q[wp] <= {par_bad, rsh_q};
            if (pop) rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
         end
         // a software write of 1 wins over the automatic clear
         if (w_ctl) crp_q <= pwdata[CTL_CRP];
         else if (ask_retx | err_hit) crp_q <= 1'b0;
      end
   end

   // character engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= S_IDLE;
         {txdir_q, retx_q, pend_q, esig_q} <= 4'h0;
         sub_q <= 11'h000;
         bit_q <= 9'h000;
         rsh_q <= 8'h00;
         {drv_q, lvl_q} <= 2'h0;
         {wt_run_q, cold_q} <= 2'h0;
         wt_q <= 24'h00_0000;
      end else if (srst_q) begin
         st_q <= S_IDLE;
         {txdir_q, retx_q, pend_q, esig_q} <= 4'h0;
         {drv_q, lvl_q} <= 2'h0;
         {wt_run_q, cold_q} <= 2'h0;
      end else begin
         drv_q <= drv_d;
         lvl_q <= lvl_d;
         if (w_txd) pend_q <= 1'b1;
         else if (start_tx) pend_q <= 1'b0;
         if (start_tx | start_rx) sub_q <= 11'h000;
         else if (cc_rise) sub_q <= (sub_q == fdr_q) ? 11'h000 : sub_q + 11'h001;
         case (st_q)
            S_IDLE: begin
               bit_q <= 9'h000;
               if (start_tx | start_rx) begin
                  st_q <= S_CHAR;
                  txdir_q <= start_tx;
                  retx_q <= 1'b0;
               end
            end
            S_CHAR: begin
               if (etu_tick) bit_q <= bit_q + 9'h001;
               if (mid_tick & ~txdir_q & (bit_q >= 9'h001) & (bit_q <= 9'h008)) begin
                  rsh_q <= msb_q ? {rsh_q[6:0], rx_bit} : {rx_bit, rsh_q[7:1]};
               end
               // receiver pulls the line low from 10.5 to 11.5 etu
               if (mid_tick & (bit_q == ERR_ETU) & retx_q & ~txdir_q) esig_q <= 1'b1;
               if (mid_tick & (bit_q == ESIG_END)) esig_q <= 1'b0;
               if (ask_retx) retx_q <= 1'b1;
               if (err_hit) retx_q <= 1'b1;
               if (~receive_enable_q & ~txdir_q) begin
                  st_q <= S_IDLE;
                  esig_q <= 1'b0;
               end else if (char_end) begin
                  bit_q <= 9'h000;
                  if (txdir_q & retx_q) begin
                     retx_q <= 1'b0;
                  end else if (txdir_q & t1_q & pend_q & transmit_enable_q) begin
                     pend_q <= 1'b0;
                  end else begin
                     st_q <= S_IDLE;
                     retx_q <= 1'b0;
                  end
               end
            end
            default: st_q <= S_IDLE;
         endcase
         // wait time measurement
         if (start_rx | wt_hit | cold_off | (~receive_enable_q & ~cold_q)) begin
            wt_run_q <= 1'b0;
            cold_q <= 1'b0;
         end
         if (cold_on & ~receive_enable_q) begin
            wt_run_q <= 1'b1;
            cold_q <= 1'b1;
            wt_q <= 24'h00_0000;
         end else if (receive_enable_up | (char_end & ~txdir_q & receive_enable_q)) begin
            wt_run_q <= 1'b1;
            wt_q <= 24'h00_0000;
         end else if (wt_run_q & etu_tick) begin
            wt_q <= wt_q + 24'h00_0001;
         end
      end
   end
endmodule

// ---- dv/ssc_top_props.sv ----
`timescale 1ns/1ps
module ssc_top_props
   import ssc_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb slave
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // clocks and debug
   input wire logic [3:0]  source_tick,
   input wire logic        debug_halt,
   // card pins
   input wire logic        card_io_in,
   input wire logic        card_io_out,
   input wire logic        card_io_oe,
   input wire logic        card_clock_in,
   input wire logic        card_clock_out,
   input wire logic        card_clock_oe,
   input wire logic        irq
);
   logic       rd;
   logic       wr;
   logic       od_q, mst_q, cpol_q, on_q, cko_q, debug_clock_keep_q;
   logic [7:0] inte_q;
   assign rd = psel && penable && !pwrite;
   assign wr = psel && penable && pwrite;
   // shadow of the few register bits that steer the pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {od_q, cpol_q, mst_q} <= 3'h5;
         {on_q, cko_q, debug_clock_keep_q} <= 3'h0;
         inte_q <= 8'h00;
      end else if (wr) begin
         if (paddr == OFS_MOD) {od_q, cpol_q, mst_q} <= pwdata[2:0];
         if (paddr == OFS_CTL) {cko_q, on_q} <= {pwdata[CTL_CKO], pwdata[CTL_ON]};
         if (paddr == OFS_CLK && !on_q) debug_clock_keep_q <= pwdata[CLK_DEBUG_CLOCK_KEEP];
         if (paddr == OFS_INTE) inte_q <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_clock_role: assert property (card_clock_oe == mst_q)
      else $error("card clock drive does not follow role");
   a_idle_level: assert property ((mst_q && !cko_q && $stable(cpol_q)) [*3]
      |-> card_clock_out == cpol_q) else $error("stopped card clock at wrong level");
   a_clock_runs: assert property (on_q && cko_q && mst_q && !debug_halt
      |-> ##[1:8] $changed(card_clock_out)) else $error("card clock not running");
   a_debug_stop: assert property ((debug_halt && !debug_clock_keep_q) [*3]
      |-> $stable(card_clock_out)) else $error("card clock runs in debug halt");
   a_open_drain: assert property (od_q && card_io_oe |-> !card_io_out)
      else $error("open drain pin driven high");
   a_tx_gated: assert property ($rose(card_io_oe) |-> on_q)
      else $error("io driven while module off");
   a_irq_masked: assert property (inte_q == 8'h00 |-> !irq)
      else $error("irq with all enables clear");
   a_reserved_hi: assert property (rd |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   c_tx_start: cover property ($rose(card_io_oe));
   c_irq_set: cover property ($rose(irq));
   c_unmapped: cover property (pslverr);
endmodule
bind ssc_top ssc_top_props i_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .source_tick(source_tick), .debug_halt(debug_halt),
   .card_io_in(card_io_in), .card_io_out(card_io_out), .card_io_oe(card_io_oe),
   .card_clock_in(card_clock_in), .card_clock_out(card_clock_out),
   .card_clock_oe(card_clock_oe), .irq(irq));

// ---- dv/ssc_card_model.sv ----
`timescale 1ns/1ps
module ssc_card_model (
   // card pins
   input  wire logic       card_clk,
   input  wire logic       io_line,
   // control
   input  wire logic       send,
   input  wire logic [7:0] send_byte,
   input  wire logic       bad_parity,
   input  wire logic [3:0] etu_len,
   // results
   output logic            drive_low,
   output logic            busy,
   output logic [8:0]      got,
   output logic            nack_seen
);
   logic [9:0] frame;
   logic [8:0] sh;
   initial begin
      drive_low = 1'b0;
      busy = 1'b0;
      got = 9'h000;
      nack_seen = 1'b0;
   end
   // start, data lsb first, even parity; then look for the error signal
   always @(posedge send) begin
      busy = 1'b1;
      frame = {^send_byte ^ bad_parity, send_byte, 1'b0};
      for (int i = 0; i < 10; i++) begin
         drive_low = !frame[i];
         repeat (etu_len) @(posedge card_clk);
      end
      drive_low = 1'b0;
      // error signal stands 10.5 to 11.5 etu: look at 11.5 etu, near its end
      repeat (etu_len + etu_len / 2) @(posedge card_clk);
      nack_seen = !io_line;
      repeat (etu_len) @(posedge card_clk);
      busy = 1'b0;
   end
   // mid-bit sampling; idle line rests high on the pull-up
   always @(negedge io_line) begin
      if (!busy) begin
         repeat (etu_len / 2) @(posedge card_clk);
         for (int i = 0; i < 9; i++) begin
            repeat (etu_len) @(posedge card_clk);
            sh[i] = io_line;
         end
         got = sh;
      end
   end
endmodule

// ---- dv/ssc_top_tb.sv ----
`timescale 1ns/1ps
module ssc_top_tb;
   import ssc_pkg::*;
   logic        pclk = 0;
   logic        presetn = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic        debug_halt = 0;
   logic        send = 0;
   logic        bad = 0;
   logic [7:0]  paddr = '0;
   logic [7:0]  sbyte = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, q;
   logic        pready, pslverr, err, io_out, io_oe, ck_out, ck_oe, irq, card_low, busy, nack;
   logic        io_line;
   logic [8:0]  got;
   int          miscompares = 0;
   int          comparisons = 0;
   // pull-up on the card line
   assign io_line = !((io_oe && !io_out) || card_low);
   always #4 pclk = ~pclk;
   ssc_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .source_tick(4'hF), .debug_halt(debug_halt), .card_io_in(io_line),
      .card_io_out(io_out), .card_io_oe(io_oe), .card_clock_in(1'b0),
      .card_clock_out(ck_out), .card_clock_oe(ck_oe), .irq(irq));
   ssc_card_model i_card (.card_clk(ck_out), .io_line(io_line), .send(send),
      .send_byte(sbyte), .bad_parity(bad), .etu_len(4'h4), .drive_low(card_low),
      .busy(busy), .got(got), .nack_seen(nack));
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e,
                         input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      cmp(what, e & m, q & m);
   endtask
   task automatic wait_flag(input int b);
      int n;
      n = 0;
      do apb(1'b0, OFS_INTF, 32'h0); while (q[b] !== 1'b1 && ++n < 100);
      cmp("event flag", 32'h1, {31'h0, q[b]});
   endtask
   task automatic card_send(input logic [7:0] b, input logic p);
      sbyte <= b;
      bad <= p;
      send <= 1'b1;
      @(posedge pclk);
      send <= 1'b0;
      do @(posedge pclk); while (busy !== 1'b0);
   endtask
   task automatic toggles(input logic halt, output int n);
      logic p;
      debug_halt <= halt;
      repeat (3) @(posedge pclk);
      n = 0;
      repeat (8) begin
         p = ck_out;
         @(posedge pclk);
         n += int'(ck_out !== p);
      end
      debug_halt <= 1'b0;
   endtask
   task automatic t_reset;
      logic [7:0] a [11] = '{OFS_CLK, OFS_MOD, OFS_BR, OFS_CTL, OFS_TXD, OFS_RXD,
                             OFS_WTC0, OFS_WTC1, OFS_GTC, OFS_INTF, OFS_INTE};
      for (int i = 0; i < 11; i++)
         rd_chk("reset value", a[i],
                i == 1 ? 32'h5 : i == 2 ? 32'h173 : 32'(i == 9), '1);
      $display("reset test done");
   endtask
   task automatic t_regs;
      logic [7:0]  a [6] = '{OFS_MOD, OFS_BR, OFS_GTC, OFS_WTC0, OFS_WTC1, OFS_CLK};
      logic [31:0] e [6] = '{32'hF7, 32'h7FF, 32'hFF, 32'hFFFF, 32'hFF, 32'h133};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, a[i], '1);
         rd_chk("register bits", a[i], e[i], '1);
      end
      apb(1'b1, OFS_CTL, 32'h1);
      apb(1'b1, OFS_CLK, 32'h0);
      rd_chk("clock locked", OFS_CLK, 32'h133, '1);
      apb(1'b1, OFS_CTL, 32'h0);
      apb(1'b1, OFS_CLK, 32'h0);
      rd_chk("clock written", OFS_CLK, 32'h0, '1);
      apb(1'b0, 8'h2C, 32'h0);
      cmp("unmapped error", 32'h1, {31'h0, err});
      for (int i = 0; i < 5; i++) apb(1'b1, a[i], i == 0 ? 32'h5 : i == 1 ? 32'h3 : 32'h0);
      $display("register test done");
   endtask
   task automatic t_debug;
      int n;
      apb(1'b1, OFS_CTL, 32'h401);
      toggles(1'b1, n);
      cmp("halted clock toggles", 32'h0, n);
      apb(1'b1, OFS_CTL, 32'h0);
      apb(1'b1, OFS_CLK, 32'h100);
      apb(1'b1, OFS_CTL, 32'h401);
      toggles(1'b1, n);
      cmp("kept clock runs", 32'h1, {31'h0, n > 0});
      $display("debug test done");
   endtask
   task automatic t_tx;
      apb(1'b1, OFS_CTL, 32'h501);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, OFS_MOD, i ? 32'h55 : 32'h05);
         apb(1'b1, OFS_TXD, 32'h35);
         rd_chk("tx empty", OFS_INTF, 32'h0, 32'h1);
         wait_flag(F_TEND);
         cmp("line byte", i ? 32'h1AC : 32'h035, {23'h0, got});
         apb(1'b1, OFS_INTF, 32'h0);
         rd_chk("flag kept", OFS_INTF, 32'h41, 32'h41);
         apb(1'b1, OFS_INTF, 32'hFF);
         rd_chk("flags cleared", OFS_INTF, 32'h1, 32'hFF);
      end
      apb(1'b1, OFS_CTL, 32'h401);
      apb(1'b1, OFS_TXD, 32'h11);
      rd_chk("tx refused", OFS_TXD, 32'h35, 32'hFF);
      $display("transmit test done");
   endtask
   task automatic t_rx;
      apb(1'b1, OFS_MOD, 32'h05);
      apb(1'b1, OFS_CTL, 32'h601);
      card_send(8'h3C, 1'b0);
      wait_flag(F_RB1);
      card_send(8'h81, 1'b0);
      wait_flag(F_RB2);
      rd_chk("oldest byte", OFS_RXD, 32'h03C, '1);
      rd_chk("full flags", OFS_INTF, 32'h0, 32'h6);
      rd_chk("next byte", OFS_RXD, 32'h081, '1);
      apb(1'b1, OFS_CTL, 32'h611);
      card_send(8'h5A, 1'b1);
      wait_flag(F_PE);
      rd_chk("parity fail byte", OFS_RXD, 32'h15A, '1);
      rd_chk("repeat cleared", OFS_CTL, 32'h0, 32'h10);
      cmp("error signal", 32'h1, {31'h0, nack});
      $display("receive test done");
   endtask
   task automatic t_cold;
      apb(1'b1, OFS_CTL, 32'h003);
      rd_chk("soft reset flags", OFS_INTF, 32'h1, 32'hFF);
      rd_chk("soft reset done", OFS_CTL, 32'h1, 32'h3);
      apb(1'b1, OFS_WTC0, 32'h4);
      apb(1'b1, OFS_CTL, 32'hC01);
      rd_chk("wait counting", OFS_CTL, 32'h800, 32'h800);
      rd_chk("wait active", OFS_INTF, 32'h800, 32'h880);
      wait_flag(F_WTE);
      apb(1'b1, OFS_INTE, 32'h80);
      @(negedge pclk);
      cmp("irq raised", 32'h1, {31'h0, irq});
      apb(1'b1, OFS_INTF, 32'h80);
      @(negedge pclk);
      cmp("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b1, OFS_CTL, 32'hC01);
      apb(1'b1, OFS_CTL, 32'h1);
      rd_chk("wait stopped", OFS_CTL, 32'h0, 32'h800);
      $display("wait test done");
   endtask
   task automatic wrap_up;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_regs;
      t_debug;
      t_tx;
      t_rx;
      t_cold;
      wrap_up;
   end
   // whole run needs well under 10000 cycles
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      wrap_up;
   end
endmodule
